//--- common/tsr_pkg.sv
// Shared constants and types of the thermal sensor register set.
package tsr_pkg;

  // ----------------------------------------------------------------------
  // Register selector values
  // ----------------------------------------------------------------------
  typedef logic [2:0] tsr_ptr_t;

  localparam tsr_ptr_t PTR_TEMP = 3'h0;
  localparam tsr_ptr_t PTR_CONF = 3'h1;
  localparam tsr_ptr_t PTR_REL  = 3'h2;
  localparam tsr_ptr_t PTR_TRIP = 3'h3;

  // ----------------------------------------------------------------------
  // Operating settings field positions
  // ----------------------------------------------------------------------
  localparam int CONF_SHDN_BIT = 0;
  localparam int CONF_MODE_BIT = 1;
  localparam int CONF_POL_BIT  = 2;
  localparam int CONF_FQ_LSB   = 3;
  localparam int CONF_RSV_LSB  = 5;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int TEMP_W = 11;
  localparam int LIM_W  = 9;
  localparam int WORD_W = 16;

  localparam logic [7:0]  CONF_RST = 8'h00;
  localparam logic [10:0] TEMP_RST = 11'h000;
  localparam logic [8:0]  TRIP_RST = 9'h0a0;
  localparam logic [8:0]  REL_RST  = 9'h096;
  localparam logic [6:0]  DEV_ADDR_DEF = 7'h48;

  // ----------------------------------------------------------------------
  // Consecutive fault counts per select code
  // ----------------------------------------------------------------------
  localparam logic [2:0] FQ_CNT0 = 3'h1;
  localparam logic [2:0] FQ_CNT1 = 3'h2;
  localparam logic [2:0] FQ_CNT2 = 3'h4;
  localparam logic [2:0] FQ_CNT3 = 3'h6;

  // ----------------------------------------------------------------------
  // Link engine states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    LS_IDLE  = 5'b00001,
    LS_ADDR  = 5'b00010,
    LS_PTR   = 5'b00100,
    LS_WDATA = 5'b01000,
    LS_RDATA = 5'b10000
  } tsr_link_e;

endpackage

//--- rtl/tsr_link.sv
// Two-wire link engine of the thermal sensor, clocked by the bus clock.
`timescale 1ns/1ps
module tsr_link #(
  parameter logic [6:0] DEV_ADDR = tsr_pkg::DEV_ADDR_DEF
) (
  // Link clock and reset request
  input  wire logic              scl,
  input  wire logic              srst,
  // Data line, open drain
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  // Register image from the system clock side
  input  wire logic [15:0]       snap_temp,
  input  wire logic [15:0]       snap_conf,
  input  wire logic [15:0]       snap_rel,
  input  wire logic [15:0]       snap_trip,
  input  wire logic              snap_tgl,
  output logic                   snap_ack,
  // Writes and read events toward the system clock side
  output tsr_pkg::tsr_ptr_t      wr_ptr,
  output logic [15:0]            wr_data,
  output logic                   wr_tgl,
  output logic                   rd_tgl
);
  import tsr_pkg::*;

  logic             sda_pos_q;
  logic             start_tgl_q;
  logic [2:0]       rst_s_q, rst_s_d;
  logic [2:0]       snp_s_q, snp_s_d;
  logic             link_rst;
  tsr_link_e        st_q, st_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [6:0]       shr_q, shr_d;
  logic             rw_q, rw_d;
  tsr_ptr_t         ptr_q, ptr_d;
  logic             idx_q, idx_d;
  logic [7:0]       hi_q, hi_d;
  logic [15:0]      tx_q, tx_d;
  logic             oe_n_q, oe_n_d;
  logic             seen_q, seen_d;
  logic             ack_q, ack_d;
  logic [3:0][15:0] img_q, img_d;
  tsr_ptr_t         wr_ptr_q, wr_ptr_d;
  logic [15:0]      wr_data_q, wr_data_d;
  logic             wr_tgl_q, wr_tgl_d;
  logic             rd_tgl_q, rd_tgl_d;
  logic [7:0]       byte_w;
  logic [15:0]      word_w;

  // ----------------------------------------------------------------------
  // Bus condition capture
  // ----------------------------------------------------------------------
  // A falling data line while the clock is high marks a frame start; the
  // toggle is read at the next clock fall, which the bus timing places well
  // after it.
  always_ff @(posedge scl) begin
    sda_pos_q <= sda_i;
  end

  always_ff @(negedge sda_i or posedge srst) begin
    if (srst) begin
      start_tgl_q <= 1'b0;
    end else if (scl) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  assign link_rst = rst_s_q[2] & rst_s_q[1];

  // ----------------------------------------------------------------------
  // Byte engine, one step per clock fall
  // ----------------------------------------------------------------------
  always_comb begin
    byte_w    = {shr_q, sda_pos_q};
    rst_s_d   = {rst_s_q[1:0], srst};
    snp_s_d   = {snp_s_q[1:0], snap_tgl};
    st_d      = st_q;
    cnt_d     = cnt_q;
    shr_d     = shr_q;
    rw_d      = rw_q;
    ptr_d     = ptr_q;
    idx_d     = idx_q;
    hi_d      = hi_q;
    tx_d      = tx_q;
    oe_n_d    = 1'b1;
    seen_d    = seen_q;
    ack_d     = ack_q;
    img_d     = img_q;
    wr_ptr_d  = wr_ptr_q;
    wr_data_d = wr_data_q;
    wr_tgl_d  = wr_tgl_q;
    rd_tgl_d  = rd_tgl_q;
    word_w    = ptr_q[2] ? 16'h0000 : img_q[ptr_q[1:0]];
    if (snp_s_q[2] == snp_s_q[1] && snp_s_q[2] != ack_q) begin
      img_d = {snap_trip, snap_rel, snap_conf, snap_temp};
      ack_d = snp_s_q[2];
    end
    if (start_tgl_q != seen_q) begin
      seen_d = start_tgl_q;
      st_d   = LS_ADDR;
      cnt_d  = 4'h0;
    end else if (st_q != LS_IDLE && cnt_q != 4'h8) begin
      shr_d = byte_w[6:0];
      cnt_d = cnt_q + 4'h1;
      case (st_q)
        LS_ADDR: begin
          if (cnt_q == 4'h7 && byte_w[7:1] == DEV_ADDR) begin
            oe_n_d = 1'b0;
            rw_d   = byte_w[0];
          end else if (cnt_q == 4'h7) begin
            st_d = LS_IDLE;
          end
        end
        LS_PTR: begin
          if (cnt_q == 4'h7) begin
            oe_n_d = 1'b0;
            ptr_d  = byte_w[2:0];
          end
        end
        LS_WDATA: begin
          if (cnt_q == 4'h7) begin
            oe_n_d = 1'b0;
            hi_d   = byte_w;
            idx_d  = ~idx_q;
            if (!idx_q && ptr_q == PTR_CONF) begin
              wr_ptr_d  = ptr_q;
              wr_data_d = {byte_w, 8'h00};
              wr_tgl_d  = ~wr_tgl_q;
            end else if (idx_q && ptr_q != PTR_CONF) begin
              wr_ptr_d  = ptr_q;
              wr_data_d = {hi_q, byte_w};
              wr_tgl_d  = ~wr_tgl_q;
            end
          end
        end
        LS_RDATA: begin
          if (cnt_q != 4'h7) begin
            oe_n_d = tx_q[15];
            tx_d   = {tx_q[14:0], tx_q[15]};
          end
        end
        default: begin
          st_d = LS_IDLE;
        end
      endcase
    end else if (st_q != LS_IDLE) begin
      cnt_d = 4'h0;
      case (st_q)
        LS_ADDR: begin
          if (rw_q) begin
            st_d     = LS_RDATA;
            oe_n_d   = word_w[15];
            tx_d     = {word_w[14:0], word_w[15]};
            rd_tgl_d = ~rd_tgl_q;
          end else begin
            st_d = LS_PTR;
          end
        end
        LS_PTR: begin
          st_d  = LS_WDATA;
          idx_d = 1'b0;
        end
        LS_RDATA: begin
          if (sda_pos_q) begin
            st_d = LS_IDLE;
          end else begin
            oe_n_d = tx_q[15];
            tx_d   = {tx_q[14:0], tx_q[15]};
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(negedge scl) begin
    rst_s_q <= rst_s_d;
    snp_s_q <= snp_s_d;
    if (link_rst) begin
      st_q      <= LS_IDLE;
      cnt_q     <= 4'h0;
      shr_q     <= 7'h00;
      rw_q      <= 1'b0;
      ptr_q     <= PTR_TEMP;
      idx_q     <= 1'b0;
      hi_q      <= 8'h00;
      tx_q      <= 16'h0000;
      oe_n_q    <= 1'b1;
      seen_q    <= 1'b0;
      ack_q     <= 1'b0;
      img_q     <= '0;
      wr_ptr_q  <= PTR_TEMP;
      wr_data_q <= 16'h0000;
      wr_tgl_q  <= 1'b0;
      rd_tgl_q  <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      shr_q     <= shr_d;
      rw_q      <= rw_d;
      ptr_q     <= ptr_d;
      idx_q     <= idx_d;
      hi_q      <= hi_d;
      tx_q      <= tx_d;
      oe_n_q    <= oe_n_d;
      seen_q    <= seen_d;
      ack_q     <= ack_d;
      img_q     <= img_d;
      wr_ptr_q  <= wr_ptr_d;
      wr_data_q <= wr_data_d;
      wr_tgl_q  <= wr_tgl_d;
      rd_tgl_q  <= rd_tgl_d;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = oe_n_q;
  assign snap_ack = ack_q;
  assign wr_ptr   = wr_ptr_q;
  assign wr_data  = wr_data_q;
  assign wr_tgl   = wr_tgl_q;
  assign rd_tgl   = rd_tgl_q;

endmodule

//--- rtl/tsr_regs.sv
// Register set, limit watchdog and alarm pin of the thermal sensor.
//
// How it works
// - Settings bits 7:5 are plain storage, reset zero, steering nothing.
// - Fault select 00/01/10/11 needs 1/2/4/6 consecutive faults; resets 00.
// - Settings bit 1 picks comparator (0, reset) or interrupt (1) alarm.
// - Settings bit 0 picks normal (0, reset) or shutdown (1) operation.
// - Reading register is read only, loaded at each finished conversion outside shutdown.
// - Reading is 11-bit two's complement, left aligned, low five bits zero.
// - A reading read sends all sixteen bits, upper byte first.
// - A reading read may stop after the upper byte.
// - Both limits are 9-bit two's complement, left aligned, read/write.
// - Each finished conversion outside shutdown is compared with the watched limit, trip or release, to steer alarm.
// - The comparison uses only the nine upper reading bits.
// - Limit low byte bits 6:0 always read as zero.
// - A limit read may stop after the upper byte without effect.
// - The register selector comes out of reset pointing at the reading.
// - In interrupt mode an active alarm stays until any register read or shutdown.
// - In comparator mode the alarm changes only after the selected run of faults.
// - Settings bit 2 sets alarm active level: high at 1, low at 0.
`timescale 1ns/1ps
module tsr_regs #(
  parameter logic [6:0] DEV_ADDR = tsr_pkg::DEV_ADDR_DEF
) (
  // System clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // Two-wire bus, clock and open-drain data
  input  wire logic                        scl,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe_n,
  // Converter
  input  wire logic                        conv_done,
  input  wire logic [tsr_pkg::TEMP_W-1:0]  conv_data,
  output logic                             conv_run,
  // Alarm pin, open drain
  input  wire logic                        alarm_output_i,
  output logic                             alarm_output_o,
  output logic                             alarm_output_oe_n
);
  import tsr_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]        conf_q, conf_d;
  logic [TEMP_W-1:0] temp_q, temp_d;
  logic [LIM_W-1:0]  trip_q, trip_d;
  logic [LIM_W-1:0]  rel_q, rel_d;
  logic              watch_rel_q, watch_rel_d;
  logic [2:0]        fcnt_q, fcnt_d;
  logic              pend_q, pend_d;
  logic              pin_low_q, pin_low_d;
  logic [2:0]        s1_q, s2_q, s3_q;
  logic [2:0]        s1_d, s2_d, s3_d;
  logic [1:0]        seen_q, seen_d;
  logic              snap_tgl_q, snap_tgl_d;
  logic [15:0]       snap_temp_q, snap_temp_d;
  logic [15:0]       snap_conf_q, snap_conf_d;
  logic [15:0]       snap_rel_q, snap_rel_d;
  logic [15:0]       snap_trip_q, snap_trip_d;
  tsr_ptr_t          wr_ptr;
  logic [15:0]       wr_data;
  logic              wr_tgl;
  logic              rd_tgl;
  logic              snap_ack;
  logic              wr_ev;
  logic              rd_ev;
  logic              snap_done;
  logic              shdn;
  logic              irq_mode;
  logic              polarity;
  logic              step;
  logic              fault;
  logic              active;
  logic [2:0]        fq_need;
  logic [LIM_W-1:0]  temp9;

  // ----------------------------------------------------------------------
  // Link engine on the bus clock
  // ----------------------------------------------------------------------
  tsr_link #(
    .DEV_ADDR (DEV_ADDR)
  ) tsr_link_inst (
    .scl       (scl),
    .srst      (srst),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe_n  (sda_oe_n),
    .snap_temp (snap_temp_q),
    .snap_conf (snap_conf_q),
    .snap_rel  (snap_rel_q),
    .snap_trip (snap_trip_q),
    .snap_tgl  (snap_tgl_q),
    .snap_ack  (snap_ack),
    .wr_ptr    (wr_ptr),
    .wr_data   (wr_data),
    .wr_tgl    (wr_tgl),
    .rd_tgl    (rd_tgl)
  );

  // ----------------------------------------------------------------------
  // Crossings from the bus clock
  // ----------------------------------------------------------------------
  // Bit 0 carries writes, bit 1 read events, bit 2 the image acknowledge.
  // Write words stay still on the link side for at least nine bus clocks,
  // far longer than this path takes, so they are read once the toggle lands.
  always_comb begin
    s1_d      = {snap_ack, rd_tgl, wr_tgl};
    s2_d      = s1_q;
    s3_d      = s2_q;
    wr_ev     = (s2_q[0] == s3_q[0]) && (s3_q[0] != seen_q[0]);
    rd_ev     = (s2_q[1] == s3_q[1]) && (s3_q[1] != seen_q[1]);
    snap_done = (s2_q[2] == s3_q[2]) && (s3_q[2] == snap_tgl_q);
    seen_d    = s3_q[1:0];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q   <= 3'h0;
      s2_q   <= 3'h0;
      s3_q   <= 3'h0;
      seen_q <= 2'h0;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      seen_q <= seen_d;
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  assign shdn     = conf_q[CONF_SHDN_BIT];
  assign irq_mode = conf_q[CONF_MODE_BIT];
  assign polarity = conf_q[CONF_POL_BIT];
  assign step     = conv_done && !shdn;

  always_comb begin
    conf_d = conf_q;
    trip_d = trip_q;
    rel_d  = rel_q;
    temp_d = temp_q;
    if (step) begin
      temp_d = conv_data;
    end
    if (wr_ev) begin
      case (wr_ptr)
        PTR_CONF: conf_d = wr_data[15:8];
        PTR_TRIP: trip_d = wr_data[15:7];
        PTR_REL:  rel_d  = wr_data[15:7];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      conf_q <= CONF_RST;
      temp_q <= TEMP_RST;
      trip_q <= TRIP_RST;
      rel_q  <= REL_RST;
    end else begin
      conf_q <= conf_d;
      temp_q <= temp_d;
      trip_q <= trip_d;
      rel_q  <= rel_d;
    end
  end

  // converter runs only in normal mode
  assign conv_run = ~shdn;

  // ----------------------------------------------------------------------
  // Limit watchdog
  // ----------------------------------------------------------------------
  // One state bit says which limit is watched: the trip limit while the
  // alarm condition is off, the release limit while it is on. Both modes
  // share it, so switching mode never loses the temperature history.
  always_comb begin
    temp9 = conv_data[TEMP_W-1:TEMP_W-LIM_W];
    case (conf_q[CONF_FQ_LSB +: 2])
      2'h0:    fq_need = FQ_CNT0;
      2'h1:    fq_need = FQ_CNT1;
      2'h2:    fq_need = FQ_CNT2;
      2'h3:    fq_need = FQ_CNT3;
      default: fq_need = FQ_CNT0;
    endcase
    if (watch_rel_q) begin
      fault = $signed(temp9) < $signed(rel_q);
    end else begin
      fault = $signed(temp9) > $signed(trip_q);
    end
    watch_rel_d = watch_rel_q;
    fcnt_d      = fcnt_q;
    pend_d      = pend_q;
    if (rd_ev) begin
      pend_d = 1'b0;
    end
    if (shdn && irq_mode) begin
      pend_d = 1'b0;
    end
    // change only after a full run
    if (step) begin
      if (!fault) begin
        fcnt_d = 3'h0;
      end else if (fcnt_q + 3'h1 >= fq_need) begin
        fcnt_d      = 3'h0;
        watch_rel_d = ~watch_rel_q;
        if (irq_mode) begin
          pend_d = 1'b1;
        end
      end else begin
        fcnt_d = fcnt_q + 3'h1;
      end
    end
    active    = irq_mode ? pend_q : watch_rel_q;
    pin_low_d = active ^ polarity;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      watch_rel_q <= 1'b0;
      fcnt_q      <= 3'h0;
      pend_q      <= 1'b0;
      pin_low_q   <= 1'b0;
    end else begin
      watch_rel_q <= watch_rel_d;
      fcnt_q      <= fcnt_d;
      pend_q      <= pend_d;
      pin_low_q   <= pin_low_d;
    end
  end

  // The pin only ever sinks; its released level comes from the pull-up.
  assign alarm_output_o    = 1'b0;
  assign alarm_output_oe_n = ~pin_low_q;

  // ----------------------------------------------------------------------
  // Register image toward the bus clock
  // ----------------------------------------------------------------------
  // A fresh image is published only once the previous one was taken, so
  // the words are still while the link side copies them. The bus clock may
  // stand between frames; the image is then refreshed during the address
  // byte of the next frame, before any data byte leaves.
  always_comb begin
    snap_tgl_d  = snap_tgl_q;
    snap_temp_d = snap_temp_q;
    snap_conf_d = snap_conf_q;
    snap_rel_d  = snap_rel_q;
    snap_trip_d = snap_trip_q;
    if (snap_done) begin
      snap_tgl_d  = ~snap_tgl_q;
      // reading left aligned, low bits zero
      snap_temp_d = {temp_q, 5'h00};
      snap_conf_d = {conf_q, conf_q};
      snap_rel_d  = {rel_q, 7'h00};
      snap_trip_d = {trip_q, 7'h00};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      snap_tgl_q  <= 1'b0;
      snap_temp_q <= 16'h0000;
      snap_conf_q <= 16'h0000;
      snap_rel_q  <= 16'h0000;
      snap_trip_q <= 16'h0000;
    end else begin
      snap_tgl_q  <= snap_tgl_d;
      snap_temp_q <= snap_temp_d;
      snap_conf_q <= snap_conf_d;
      snap_rel_q  <= snap_rel_d;
      snap_trip_q <= snap_trip_d;
    end
  end

endmodule

//--- testbench/tsr_regs_monitor.sv
// Port checker of the thermal sensor register set.
`timescale 1ns/1ps
module tsr_regs_monitor (
  // System clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus lines
  input wire logic scl,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  // Converter and alarm pin
  input wire logic conv_done,
  input wire logic conv_run,
  input wire logic alarm_output_o,
  input wire logic alarm_output_oe_n
);
  // --------------------
  // Bus quiet counter
  // --------------------
  // A long still bus clock means no write or read event can be in flight.
  logic [3:0] quiet_q, quiet_d;
  logic       scl_q, scl_d;
  logic       srst_q = 1'b0;
  always_comb begin
    scl_d = scl;
    quiet_d = quiet_q;
    if (srst || scl != scl_q) begin
      quiet_d = 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_d = quiet_q + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    scl_q <= scl_d;
    srst_q <= srst;
    quiet_q <= quiet_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // --------------------
  // Properties
  // --------------------
  property p_sda_value; sda_o == 1'b0; endproperty
  a_sda_value: assert property (p_sda_value) else $error("sda value");
  property p_alarm_value; alarm_output_o == 1'b0; endproperty
  a_alarm_value: assert property (p_alarm_value) else $error("pin value");
  property p_reset_vals;
    disable iff (1'b0) srst && srst_q |-> conv_run && alarm_output_oe_n;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset pins");
  property p_sda_hold; scl && $past(scl) |-> $stable(sda_oe_n); endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("sda moved");
  property p_sda_idle; quiet_q == 4'hf |-> sda_oe_n; endproperty
  a_sda_idle: assert property (p_sda_idle) else $error("sda held");
  property p_pin_cause;
    $changed(alarm_output_oe_n) && quiet_q == 4'hf |-> $past(conv_done, 2);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin cause");
  property p_pin_shdn;
    !conv_run && quiet_q == 4'hf |-> $stable(alarm_output_oe_n);
  endproperty
  a_pin_shdn: assert property (p_pin_shdn) else $error("pin in shdn");
  property p_run_stable; quiet_q == 4'hf |-> $stable(conv_run); endproperty
  a_run_stable: assert property (p_run_stable) else $error("run moved");
  c_conv: cover property (conv_done && conv_run);
  c_pin: cover property ($fell(alarm_output_oe_n));
  c_ack: cover property ($fell(sda_oe_n));
endmodule
bind tsr_regs tsr_regs_monitor tsr_regs_monitor_inst (.clk, .srst, .scl,
  .sda_o, .sda_oe_n, .conv_done, .conv_run, .alarm_output_o,
  .alarm_output_oe_n);

//--- testbench/tsr_ctl_model.sv
// Behavioural two-wire bus controller facing the sensor.
`timescale 1ns/1ps
module tsr_ctl_model (
  // Bus lines, data is open drain with a pull-up
  output logic      scl,
  output logic      pull_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // Data bits move 3 ns after a falling edge, start and stop move it with the clock high; sampled at the rising edge.
  task automatic tick(output logic v);
    #12 scl = 1'b1;
    v = sda;
    #15 scl = 1'b0;
    #3;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      scl = 1'b0;
      #15 scl = 1'b1;
      #15;
    end
  endtask
  task automatic start();
    if (scl) begin
      #2;
    end else begin
      pull_low = 1'b0;
      #12 scl = 1'b1;
      #15;
    end
    pull_low = 1'b1;
    #15 scl = 1'b0;
    #3;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      pull_low = !b[i];
      tick(v);
    end
    pull_low = 1'b0;
    tick(ack);
  endtask
  task automatic get(output logic [7:0] b, input logic last);
    logic v;
    pull_low = 1'b0;
    for (int i = 0; i < 8; i++) begin
      tick(v);
      b = {b[6:0], v};
    end
    pull_low = !last;
    tick(v);
    pull_low = 1'b0;
  endtask
  // The clock stays high after the stop, standing still between frames.
  task automatic stop();
    pull_low = 1'b1;
    #12 scl = 1'b1;
    #15 pull_low = 1'b0;
    #15;
  endtask
endmodule

//--- testbench/tb_tsr_regs.sv
// Self-checking bench of the thermal sensor register set.
`timescale 1ns/1ps
module tb_tsr_regs;
  import tsr_pkg::*;
  localparam logic [10:0] HOT  = 11'h0cc;
  localparam logic [10:0] MID  = 11'h0c9;
  localparam logic [10:0] COLD = 11'h09c;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        conv_done = 1'b0;
  logic [10:0] conv_data = 11'h000;
  logic        scl, pull_low, sda_i, sda_o, sda_oe_n, conv_run;
  logic        alarm_output_i, alarm_output_o, alarm_output_oe_n;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          n;
  logic [15:0] last_w;
  always #5 clk = ~clk;
  assign sda_i = !(pull_low || !sda_oe_n);
  assign alarm_output_i = alarm_output_oe_n ? 1'b1 : alarm_output_o;
  tsr_regs #(.DEV_ADDR(DEV_ADDR_DEF)) tsr_regs_inst (.clk, .srst, .scl,
    .sda_i, .sda_o, .sda_oe_n, .conv_done, .conv_data, .conv_run,
    .alarm_output_i, .alarm_output_o, .alarm_output_oe_n);
  tsr_ctl_model tsr_ctl_model_inst (.scl, .pull_low, .sda(sda_i));
  // --------------------
  // Compare and access tasks
  // --------------------
  task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    chk16(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic pin(logic e, string nm);
    @(negedge clk);
    chk1(nm, e, alarm_output_i);
  endtask
  task automatic wr(tsr_ptr_t p, logic [15:0] w, int nb);
    logic a;
    tsr_ctl_model_inst.start();
    tsr_ctl_model_inst.put({DEV_ADDR_DEF, 1'b0}, a);
    tsr_ctl_model_inst.put({5'h00, p}, a);
    if (nb > 0) tsr_ctl_model_inst.put(w[15:8], a);
    if (nb > 1) tsr_ctl_model_inst.put(w[7:0], a);
    tsr_ctl_model_inst.stop();
    repeat (10) @(posedge clk);
  endtask
  task automatic rdc(bit s, tsr_ptr_t p, int nb, logic [15:0] e, string nm);
    logic        a;
    logic [15:0] w;
    if (s) begin
      tsr_ctl_model_inst.start();
      tsr_ctl_model_inst.put({DEV_ADDR_DEF, 1'b0}, a);
      tsr_ctl_model_inst.put({5'h00, p}, a);
    end
    tsr_ctl_model_inst.start();
    tsr_ctl_model_inst.put({DEV_ADDR_DEF, 1'b1}, a);
    w = 16'h0000;
    tsr_ctl_model_inst.get(w[15:8], nb == 1);
    if (nb > 1) tsr_ctl_model_inst.get(w[7:0], 1'b1);
    tsr_ctl_model_inst.stop();
    chk16(nm, e, w);
    last_w = w;
    repeat (10) @(posedge clk);
  endtask
  task automatic conv(logic [10:0] d);
    @(posedge clk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------------------
  // Tests
  // --------------------
  initial begin
    #200_000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    fork
      tsr_ctl_model_inst.idle(5);
    join_none
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    // The link side only leaves reset on bus clock falls after the release.
    tsr_ctl_model_inst.idle(4);
    rdc(0, PTR_TEMP, 2, 16'h0000, "reading at reset");
    rdc(1, PTR_CONF, 2, 16'h0000, "settings at reset");
    rdc(1, PTR_TRIP, 2, 16'h5000, "trip at reset");
    rdc(1, PTR_REL, 2, 16'h4b00, "release at reset");
    pin(1'b1, "pin at reset");
    $display("test reset done");
    wr(PTR_CONF, 16'he000, 1);
    rdc(1, PTR_CONF, 2, 16'he0e0, "spare settings bits");
    rdc(1, 3'h5, 2, 16'h0000, "unmapped selector");
    wr(PTR_TRIP, 16'h197f, 2);
    rdc(1, PTR_TRIP, 2, 16'h1900, "trip low bits");
    wr(PTR_REL, 16'h14ff, 2);
    rdc(1, PTR_REL, 2, 16'h1480, "release bit zero");
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      n = (c == 3) ? 6 : 1 << c;
      wr(PTR_CONF, {3'h0, c[1:0], 11'h000}, 1);
      repeat (n - 1) conv(HOT);
      conv(MID);
      repeat (n - 1) conv(HOT);
      pin(1'b1, "short fault run");
      conv(HOT);
      pin(1'b0, "alarm after run");
      repeat (n - 1) conv(COLD);
      pin(1'b0, "alarm still set");
      conv(COLD);
      pin(1'b1, "alarm released");
    end
    rdc(1, PTR_TEMP, 2, {COLD, 5'h00}, "reading layout");
    chk16("nine bits", {7'h00, COLD[10:2]}, {7'h00, last_w[15:7]});
    $display("test fault count done");
    wr(PTR_CONF, 16'h0200, 1);
    conv(HOT);
    pin(1'b0, "interrupt set");
    conv(HOT);
    pin(1'b0, "interrupt held");
    rdc(1, PTR_TRIP, 1, 16'h1900, "one byte limit");
    pin(1'b1, "cleared by read");
    conv(COLD);
    pin(1'b0, "set below release");
    rdc(1, PTR_TEMP, 1, {COLD[10:3], 8'h00}, "one byte reading");
    pin(1'b1, "cleared again");
    $display("test interrupt done");
    wr(PTR_CONF, 16'h0400, 1);
    pin(1'b0, "idle with high level");
    conv(HOT);
    pin(1'b1, "active high");
    conv(COLD);
    $display("test polarity done");
    wr(PTR_CONF, 16'h0100, 1);
    @(negedge clk);
    chk1("run in shutdown", 1'b0, conv_run);
    conv(HOT);
    wr(PTR_TEMP, 16'h7fff, 2);
    rdc(1, PTR_TEMP, 2, {COLD, 5'h00}, "reading kept");
    wr(PTR_CONF, 16'h0000, 1);
    @(negedge clk);
    chk1("run restored", 1'b1, conv_run);
    $display("test shutdown done");
    print_verdict();
  end
endmodule
